// ### hw/ext_osc_map.vh
// register map and timing constants for the external oscillator control block
`ifndef EXT_OSC_MAP_VH
`define EXT_OSC_MAP_VH

// ----------------------------------------------------------------------------
// register address and reset
// ----------------------------------------------------------------------------
`define EXT_OSC_CONTROL_ADDR   8'hB1
`define EXT_OSC_CONTROL_RESET  8'h00
`define SYSCLK_SEL_RESET       3'h0
`define EXT_OSC_MODE_RESET     3'h0
`define EXT_OSC_BIAS_RESET     3'h0
`define SFR_IDLE_DATA          8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define EXT_OSC_VALID_BIT      7
`define EXT_OSC_MODE_HI        6
`define EXT_OSC_MODE_LO        4
`define EXT_OSC_RSVD_BIT       3
`define EXT_OSC_BIAS_HI        2
`define EXT_OSC_BIAS_LO        0

// ----------------------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------------------
`define MODE_OFF0              3'h0
`define MODE_OFF1              3'h1
`define MODE_EXT_CLK           3'h2
`define MODE_EXT_CLK_DIV2      3'h3
`define MODE_RC                3'h4
`define MODE_CAP               3'h5
`define MODE_XTAL              3'h6
`define MODE_XTAL_DIV2         3'h7

// ----------------------------------------------------------------------------
// system clock select code for the external oscillator
// ----------------------------------------------------------------------------
`define SYSCLK_SEL_EXT_OSC     3'h1

// ----------------------------------------------------------------------------
// stabilisation window, default edge count of the source
// ----------------------------------------------------------------------------
`define STABLE_EDGES_DEFAULT   16

`endif

// ### hw/ext_osc_halver.v
// optional divide-by-2 stage on the sampled external oscillator source
module ext_osc_halver (
    // clock and reset
    input  wire i_clk,
    input  wire i_nrst,
    // control
    input  wire i_halve,
    input  wire i_rise,
    input  wire i_src,
    // output
    output reg  o_clk
);

    reg half_q;

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            half_q <= 1'b0;
            o_clk  <= 1'b0;
        end else begin
            if (!i_halve) begin
                half_q <= 1'b0;
            end else if (i_rise) begin
                half_q <= ~half_q;
            end
            o_clk <= i_halve ? half_q : i_src;
        end
    end

endmodule // ext_osc_halver

// ### hw/external_oscillator_control.v
// external oscillator control register, mode decode, valid flag and clock path
`include "ext_osc_map.vh"

module external_oscillator_control #(
    parameter STABLE_EDGES = `STABLE_EDGES_DEFAULT,
    parameter CNT_W        = 8
) (
    // clock and reset
    input  wire       i_clk,
    input  wire       i_nrst,
    // special-function register bus
    input  wire [7:0] i_sfr_addr,
    input  wire [7:0] i_sfr_wdata,
    input  wire       i_sfr_wr,
    input  wire       i_sfr_rd,
    output reg  [7:0] o_sfr_rdata,
    // system clock source select from the clock selector register
    input  wire [2:0] i_sysclk_source_select,
    // external oscillator pin, sampled
    input  wire       i_ext_osc_in,
    // analog oscillator controls
    output reg        o_osc_enable,
    output reg        o_osc_ext_clk,
    output reg        o_osc_rc,
    output reg        o_osc_cap,
    output reg        o_osc_xtal,
    output reg  [2:0] o_ext_osc_bias_control,
    // clock path toward the system clock mux
    output reg        o_ext_osc_clk,
    output reg        o_sysclk_ext
);

    // ------------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------------
    reg  [2:0]       ext_osc_mode_select_q;
    reg  [2:0]       ext_osc_bias_control_q;
    reg              ext_osc_valid_flag_q;
    reg              src_q;
    reg  [CNT_W-1:0] stable_cnt_q;
    wire             hit;
    wire             src_rise;
    wire             wr_hit;
    wire             rd_hit;
    wire             sysclk_sel_ext;
    wire [7:0]       rdata_d;
    reg              halve;
    reg              osc_on;
    reg              ext_clk_mode;
    reg              rc_mode;
    reg              cap_mode;
    reg              xtal_mode;
    wire             halved_clk;

    assign hit      = (i_sfr_addr == `EXT_OSC_CONTROL_ADDR);
    assign src_rise = i_ext_osc_in & ~src_q;
    assign wr_hit   = i_sfr_wr & hit;
    assign rd_hit   = i_sfr_rd & hit;
    assign sysclk_sel_ext = (i_sysclk_source_select == `SYSCLK_SEL_EXT_OSC);

    // valid is masked again in the logic-clock modes so no stale count can leak out
    assign rdata_d  = {ext_osc_valid_flag_q & ~ext_clk_mode,
                       ext_osc_mode_select_q,
                       1'b0,
                       ext_osc_bias_control_q};

    // ------------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------------
    always @* begin
        osc_on       = 1'b0;
        ext_clk_mode = 1'b0;
        rc_mode      = 1'b0;
        cap_mode     = 1'b0;
        xtal_mode    = 1'b0;
        halve        = 1'b0;
        case (ext_osc_mode_select_q)
            `MODE_OFF0, `MODE_OFF1: begin
                // circuit disabled, every control except the bias output stays low
                osc_on = 1'b0;
            end
            `MODE_EXT_CLK: begin
                osc_on       = 1'b1;
                ext_clk_mode = 1'b1;
            end
            `MODE_EXT_CLK_DIV2: begin
                osc_on       = 1'b1;
                ext_clk_mode = 1'b1;
                halve        = 1'b1;
            end
            `MODE_RC: begin
                osc_on  = 1'b1;
                rc_mode = 1'b1;
            end
            `MODE_CAP: begin
                osc_on   = 1'b1;
                cap_mode = 1'b1;
            end
            `MODE_XTAL: begin
                osc_on    = 1'b1;
                xtal_mode = 1'b1;
            end
            `MODE_XTAL_DIV2: begin
                osc_on    = 1'b1;
                xtal_mode = 1'b1;
                halve     = 1'b1;
            end
            default: begin
                osc_on = 1'b0;
            end
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            ext_osc_mode_select_q  <= `EXT_OSC_MODE_RESET;
            ext_osc_bias_control_q <= `EXT_OSC_BIAS_RESET;
        end else if (wr_hit) begin
            // bit 7 and bit 3 of a write are dropped here
            ext_osc_mode_select_q  <= i_sfr_wdata[`EXT_OSC_MODE_HI:`EXT_OSC_MODE_LO];
            ext_osc_bias_control_q <= i_sfr_wdata[`EXT_OSC_BIAS_HI:`EXT_OSC_BIAS_LO];
        end
    end

    // ------------------------------------------------------------------------
    // stability detection
    // ------------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            src_q                <= 1'b0;
            stable_cnt_q         <= {CNT_W{1'b0}};
            ext_osc_valid_flag_q <= 1'b0;
        end else begin
            src_q <= i_ext_osc_in;
            // edges count only while the circuit runs on its own amplifier
            if (!osc_on || ext_clk_mode || wr_hit) begin
                // a mode change restarts the stability window
                stable_cnt_q         <= {CNT_W{1'b0}};
                ext_osc_valid_flag_q <= 1'b0;
            end else if (src_rise && !ext_osc_valid_flag_q) begin
                if (stable_cnt_q == STABLE_EDGES[CNT_W-1:0] - 1'b1) begin
                    ext_osc_valid_flag_q <= 1'b1;
                end
                stable_cnt_q <= stable_cnt_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // mode decode and read port
    // ------------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_osc_enable           <= 1'b0;
            o_osc_ext_clk          <= 1'b0;
            o_osc_rc               <= 1'b0;
            o_osc_cap              <= 1'b0;
            o_osc_xtal             <= 1'b0;
            o_ext_osc_bias_control <= `EXT_OSC_BIAS_RESET;
            o_sfr_rdata            <= `EXT_OSC_CONTROL_RESET;
        end else begin
            o_osc_enable           <= osc_on;
            o_osc_ext_clk          <= ext_clk_mode;
            o_osc_rc               <= rc_mode;
            o_osc_cap              <= cap_mode;
            o_osc_xtal             <= xtal_mode;
            o_ext_osc_bias_control <= ext_osc_bias_control_q;
            // read data stands for one cycle, the bus sees zero otherwise
            if (rd_hit) begin
                o_sfr_rdata <= rdata_d;
            end else begin
                o_sfr_rdata <= `SFR_IDLE_DATA;
            end
        end
    end

    // ------------------------------------------------------------------------
    // clock path
    // ------------------------------------------------------------------------
    // the halver clears outside halving modes so it restarts in a known phase
    ext_osc_halver ext_osc_halver_inst (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_halve(halve),
        .i_rise (src_rise),
        .i_src  (src_q),
        .o_clk  (halved_clk)
    );

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_ext_osc_clk <= 1'b0;
            o_sysclk_ext  <= 1'b0;
        end else begin
            // a disabled circuit holds the clock low instead of passing pin levels
            o_ext_osc_clk <= osc_on & halved_clk;
            o_sysclk_ext  <= sysclk_sel_ext & osc_on & halved_clk;
        end
    end

endmodule // external_oscillator_control

// ### verification/ext_osc_properties.sv
// assertions on the external oscillator control ports
module ext_osc_checker (
    // clock and reset
    input wire       i_clk,
    input wire       i_nrst,
    // special-function register bus
    input wire       i_sfr_wr,
    input wire       i_sfr_rd,
    input wire [7:0] i_sfr_addr,
    input wire [7:0] i_sfr_wdata,
    input wire [7:0] o_sfr_rdata,
    // clock select and oscillator controls
    input wire [2:0] i_sysclk_source_select,
    input wire [2:0] o_ext_osc_bias_control,
    input wire       o_osc_enable,
    input wire       o_osc_ext_clk,
    input wire       o_osc_rc,
    input wire       o_osc_cap,
    input wire       o_osc_xtal,
    // clock path
    input wire       o_ext_osc_clk,
    input wire       o_sysclk_ext
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    wire wr_hit = i_sfr_wr && i_sfr_addr == 8'hB1;
    sequence s_wr; wr_hit ##1 !wr_hit; endsequence
    property p_en; s_wr |=> o_osc_enable == ($past(i_sfr_wdata[6:5], 2) != 2'h0); endproperty
    property p_ext; s_wr |=> o_osc_ext_clk == ($past(i_sfr_wdata[6:5], 2) == 2'h1); endproperty
    property p_rc_cap;
        s_wr |=> {o_osc_rc, o_osc_cap} ==
            {$past(i_sfr_wdata[6:4], 2) == 3'h4, $past(i_sfr_wdata[6:4], 2) == 3'h5};
    endproperty
    property p_xtal; s_wr |=> o_osc_xtal == ($past(i_sfr_wdata[6:5], 2) == 2'h3); endproperty
    property p_bias; s_wr |=> o_ext_osc_bias_control == $past(i_sfr_wdata[2:0], 2); endproperty
    property p_rsvd; o_sfr_rdata[3] == 1'b0; endproperty
    property p_valid_ext; o_osc_ext_clk |-> !o_sfr_rdata[7]; endproperty
    property p_valid_mode; o_sfr_rdata[7] |-> o_osc_rc || o_osc_cap || o_osc_xtal; endproperty
    property p_sys;
        $past(i_sysclk_source_select) != 3'h1 && i_sysclk_source_select != 3'h1 |-> !o_sysclk_ext;
    endproperty
    a_en: assert property (p_en) else $error("enable decode wrong");
    a_ext: assert property (p_ext) else $error("logic clock decode wrong");
    a_rc_cap: assert property (p_rc_cap) else $error("rc or cap decode wrong");
    a_xtal: assert property (p_xtal) else $error("crystal decode wrong");
    a_bias: assert property (p_bias) else $error("bias field wrong");
    a_rsvd: assert property (p_rsvd) else $error("bit 3 read nonzero");
    a_valid_ext: assert property (p_valid_ext) else $error("valid set in clock mode");
    a_valid_mode: assert property (p_valid_mode) else $error("valid set while unused");
    a_sys: assert property (p_sys) else $error("system clock routed unselected");
endmodule // ext_osc_checker
bind external_oscillator_control ext_osc_checker ext_osc_checker_inst (
    .i_clk                 (i_clk),
    .i_nrst                (i_nrst),
    .i_sfr_wr              (i_sfr_wr),
    .i_sfr_rd              (i_sfr_rd),
    .i_sfr_addr            (i_sfr_addr),
    .i_sfr_wdata           (i_sfr_wdata),
    .o_sfr_rdata           (o_sfr_rdata),
    .i_sysclk_source_select(i_sysclk_source_select),
    .o_ext_osc_bias_control(o_ext_osc_bias_control),
    .o_osc_enable          (o_osc_enable),
    .o_osc_ext_clk         (o_osc_ext_clk),
    .o_osc_rc              (o_osc_rc),
    .o_osc_cap             (o_osc_cap),
    .o_osc_xtal            (o_osc_xtal),
    .o_ext_osc_clk         (o_ext_osc_clk),
    .o_sysclk_ext          (o_sysclk_ext)
);

// ### verification/ext_src_model.sv
// behavioural external clock source, still at low while not running
module ext_src_model #(parameter int HALF = 3) (
    input  wire  i_clk,
    input  wire  i_run,
    output logic o_src = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    always @(posedge i_clk) begin
        if (!i_run) begin cnt <= 0; o_src <= 1'b0; end
        else if (cnt == HALF - 1) begin cnt <= 0; o_src <= ~o_src; end
        else cnt <= cnt + 1;
    end
endmodule // ext_src_model

// ### verification/external_oscillator_control_bench.sv
// bench for the external oscillator control block
module external_oscillator_control_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 0, i_nrst = 0, i_sfr_wr = 0, i_sfr_rd = 0, run = 0;
    logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, q;
    logic [2:0] i_sysclk_source_select = 3'h0;
    wire [7:0] o_sfr_rdata;
    wire [2:0] o_ext_osc_bias_control;
    wire i_ext_osc_in, o_osc_enable, o_osc_ext_clk, o_osc_rc, o_osc_cap, o_osc_xtal;
    wire o_ext_osc_clk, o_sysclk_ext;
    int n_mismatch = 0, checks = 0, cycles = 0, n, n2;
    always #2.5 i_clk = ~i_clk;
    external_oscillator_control #(
        .STABLE_EDGES(4)
    ) external_oscillator_control_inst (
        .i_clk                 (i_clk),
        .i_nrst                (i_nrst),
        .i_sfr_addr            (i_sfr_addr),
        .i_sfr_wdata           (i_sfr_wdata),
        .i_sfr_wr              (i_sfr_wr),
        .i_sfr_rd              (i_sfr_rd),
        .o_sfr_rdata           (o_sfr_rdata),
        .i_sysclk_source_select(i_sysclk_source_select),
        .i_ext_osc_in          (i_ext_osc_in),
        .o_osc_enable          (o_osc_enable),
        .o_osc_ext_clk         (o_osc_ext_clk),
        .o_osc_rc              (o_osc_rc),
        .o_osc_cap             (o_osc_cap),
        .o_osc_xtal            (o_osc_xtal),
        .o_ext_osc_bias_control(o_ext_osc_bias_control),
        .o_ext_osc_clk         (o_ext_osc_clk),
        .o_sysclk_ext          (o_sysclk_ext)
    );
    ext_src_model ext_src_model_inst (.i_clk(i_clk), .i_run(run), .o_src(i_ext_osc_in));
    task automatic finish_test();
        if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge i_clk); i_sfr_wr <= 1; i_sfr_addr <= a; i_sfr_wdata <= d;
        @(posedge i_clk); i_sfr_wr <= 0;
        @(posedge i_clk); #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk); i_sfr_rd <= 1; i_sfr_addr <= a;
        @(posedge i_clk); i_sfr_rd <= 0;
        #1 q = o_sfr_rdata;
    endtask
    // rising edges of the routed and the plain clock over 120 cycles
    task automatic count();
        logic p;
        logic r;
        n = 0;
        n2 = 0;
        p = o_sysclk_ext;
        r = o_ext_osc_clk;
        repeat (120) begin
            @(posedge i_clk);
            #1;
            if (o_sysclk_ext && !p) n++;
            if (o_ext_osc_clk && !r) n2++;
            p = o_sysclk_ext;
            r = o_ext_osc_clk;
        end
    endtask
    // every mode and bias code, reserved bit written as zero
    task automatic t_modes();
        for (int i = 0; i < 8; i++) begin
            logic [2:0] m;
            logic [7:0] e;
            m = 3'(i);
            e = {m[2] | m[1], m[2:1] == 2'h1, m == 3'h4, m == 3'h5, m[2:1] == 2'h3, m};
            wr(8'hB1, {1'b0, m, 1'b0, m});
            check({o_osc_enable, o_osc_ext_clk, o_osc_rc, o_osc_cap, o_osc_xtal,
                   o_ext_osc_bias_control}, e);
            rd(8'hB1); check(q, {1'b0, m, 1'b0, m});
        end
        rd(8'hB2); check(q, 8'h00);
        wr(8'hB2, 8'h12); rd(8'hB1); check(q, 8'h77);
    endtask
    // valid flag only after the source settles, never in logic clock mode
    task automatic t_valid();
        run <= 1;
        wr(8'hB1, 8'h40); rd(8'hB1); check(q, 8'h40);
        repeat (60) @(posedge i_clk); rd(8'hB1); check(q, 8'hC0);
        wr(8'hB1, 8'h60); repeat (10) @(posedge i_clk); rd(8'hB1); check(q, 8'h60);
        repeat (50) @(posedge i_clk); rd(8'hB1); check(q, 8'hE0);
        wr(8'hB1, 8'h20); repeat (60) @(posedge i_clk); rd(8'hB1); check(q, 8'h20);
        wr(8'hB1, 8'h00); repeat (60) @(posedge i_clk); rd(8'hB1); check(q, 8'h00);
    endtask
    // full and halved source on the system clock path, then unselected
    task automatic t_halve();
        i_sysclk_source_select <= 3'h1;
        wr(8'hB1, 8'h20); repeat (20) @(posedge i_clk); count(); check(8'(n), 8'h14);
        check(8'(n2), 8'h14);
        wr(8'hB1, 8'h30); repeat (20) @(posedge i_clk); count(); check(8'(n), 8'h0A);
        check(8'(n2), 8'h0A);
        i_sysclk_source_select <= 3'h0;
        repeat (4) @(posedge i_clk); count(); check(8'(n), 8'h00);
        check(8'(n2), 8'h0A);
        wr(8'hB1, 8'h00); repeat (4) @(posedge i_clk); count(); check(8'(n2), 8'h00);
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        i_nrst <= 1;
        t_modes();
        t_valid();
        t_halve();
        finish_test();
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin n_mismatch++; finish_test(); end
    end
endmodule // external_oscillator_control_bench
